// File: rtl/spwm_pkg.sv
// Package for the shared time-base PWM block: offsets, fields, resets, types.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package spwm_pkg;
   // ----------------------------------------------------------------------
   // Register offsets (byte addresses).
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFF_CON    = 8'h00;
   localparam logic [7:0] OFF_DCH    = 8'h04;
   localparam logic [7:0] OFF_DCL    = 8'h08;
   localparam logic [7:0] CH_STRIDE  = 8'h10;
   localparam logic [7:0] OFF_PERIOD = 8'h40;
   localparam logic [7:0] OFF_TBCTL  = 8'h44;
   localparam logic [7:0] OFF_COUNT  = 8'h48;
   localparam logic [7:0] OFF_STAT   = 8'h4C;
   localparam logic [7:0] OFF_LATCH  = 8'h50;
   localparam logic [7:0] OFF_DIR    = 8'h54;
   // ----------------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------------
   localparam int CON_ON   = 7;
   localparam int CON_DRV  = 6;
   localparam int CON_LVL  = 5;
   localparam int CON_INV  = 4;
   localparam int DCL_LSB  = 6;
   localparam int TB_PS    = 0;
   localparam int TB_RUN   = 2;
   localparam int TB_POST  = 3;
   localparam int STAT_FLG = 0;
   // ----------------------------------------------------------------------
   // Reset values, bus answers and the divider width.
   // ----------------------------------------------------------------------
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [6:0] TBCTL_RST  = 7'h00;
   localparam logic [9:0] DUTY_RST   = 10'h000;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_ERR   = 2'h2;
   localparam int         DIV_W      = 8;
   // Per-channel control bits that software writes.
   typedef struct packed {
      logic on;
      logic drive;
      logic inv;
   } spwm_ctl_t;
endpackage

// File: rtl/spwm_top.sv
// Shared time-base PWM: one 8-bit period timer, four 10-bit duty channels.
// Assumes an AXI4-Lite master on core_clk and an asynchronous sleep request.
`timescale 1ns/1ps
module spwm_top #(
   parameter int NCH    = 4,
   parameter int ADDR_W = 8
) (
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              sleep_req,
   output logic [NCH-1:0]         pin_out,
   output logic [NCH-1:0]         pin_oe
);
   // ----------------------------------------------------------------------
   // Helper functions.
   // ----------------------------------------------------------------------
   // Last divider value of one timer step: four clocks times the prescale.
   function automatic logic [7:0] div_max(input logic [1:0] ps);
      case (ps)
         2'h0:    div_max = 8'h03;
         2'h1:    div_max = 8'h0F;
         2'h2:    div_max = 8'h3F;
         default: div_max = 8'hFF;
      endcase
   endfunction

   // Two low time-base bits: clock phase at 1:1, top prescaler bits otherwise.
   function automatic logic [1:0] sub_bits(input logic [7:0] d, input logic [1:0] ps);
      case (ps)
         2'h0:    sub_bits = d[1:0];
         2'h1:    sub_bits = d[3:2];
         2'h2:    sub_bits = d[5:4];
         default: sub_bits = d[7:6];
      endcase
   endfunction

   // Byte address of a channel register.
   function automatic logic [7:0] ch_addr(input int i, input logic [7:0] off);
      ch_addr = 8'(i * 16) + off;
   endfunction

   // ----------------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------------
   spwm_pkg::spwm_ctl_t ctl_reg [NCH];
   logic [7:0]  dch_reg [NCH];
   logic [1:0]  dcl_reg [NCH];
   logic [9:0]  duty_buf_reg [NCH];
   logic [NCH-1:0] raw_reg;
   logic [7:0]  period_reg;
   logic [6:0]  tbctl_reg;
   logic [7:0]  count_reg;
   logic [spwm_pkg::DIV_W-1:0] div_reg;
   logic        flag_reg;
   logic [NCH-1:0] latch_reg;
   logic [NCH-1:0] dir_reg;
   logic        s1_reg, s2_reg, s3_reg, asleep_reg;
   logic        aw_have_reg, w_have_reg;
   logic [7:0]  wa_reg;
   logic [7:0]  wd_reg;
   logic        wstb_reg;

   // ----------------------------------------------------------------------
   // Time base.
   // ----------------------------------------------------------------------
   // The postscale field is only stored and read back; no time-base logic uses it.
   wire [1:0] ps         = tbctl_reg[spwm_pkg::TB_PS +: 2];
   wire       run        = tbctl_reg[spwm_pkg::TB_RUN] & ~asleep_reg;
   wire       tick       = run & (div_reg == div_max(ps));
   wire       period_hit = tick & (count_reg == period_reg);
   wire [9:0] tb_now     = {count_reg, sub_bits(div_reg, ps)};
   wire [9:0] tb_full    = {period_reg, 2'h3};

   // Sleep request passes three flops; a change counts once stages two and three agree.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s1_reg     <= 1'b0;
         s2_reg     <= 1'b0;
         s3_reg     <= 1'b0;
         asleep_reg <= 1'b0;
      end else begin
         s1_reg <= sleep_req;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            asleep_reg <= s3_reg;
         end
      end
   end

   // Divider and timer; both hold their count through sleep.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div_reg   <= '0;
         count_reg <= 8'h00;
      end else if (run) begin
         div_reg <= tick ? '0 : div_reg + 8'h01;
         if (period_hit) begin
            count_reg <= 8'h00;
         end else if (tick) begin
            count_reg <= count_reg + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Channels.
   // ----------------------------------------------------------------------
   logic [NCH-1:0] lvl;
   logic [NCH-1:0] full;
   logic [NCH-1:0] start;
   logic [NCH-1:0] hit;
   logic [NCH-1:0] raw_next;

   // Set at the restart of the time base, clear at the duty match; a zero
   // duty hits both at once and the clear wins, so it stays inactive.
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         full[i]  = duty_buf_reg[i] > tb_full;
         start[i] = run & (tb_now == 10'h000);
         hit[i]   = run & (tb_now == duty_buf_reg[i]) & ~full[i];
         lvl[i]   = raw_reg[i] ^ ctl_reg[i].inv;
         if (!ctl_reg[i].on) begin
            raw_next[i] = 1'b0;
         end else if (hit[i]) begin
            raw_next[i] = 1'b0;
         end else if (start[i]) begin
            raw_next[i] = 1'b1;
         end else begin
            raw_next[i] = raw_reg[i];
         end
      end
   end

   // Duty buffers load only at the period match; writes never touch them.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         raw_reg <= '0;
         pin_out <= '0;
         pin_oe  <= '0;
         for (int i = 0; i < NCH; i++) begin
            duty_buf_reg[i] <= spwm_pkg::DUTY_RST;
         end
      end else begin
         raw_reg <= raw_next;
         for (int i = 0; i < NCH; i++) begin
            if (period_hit) begin
               duty_buf_reg[i] <= {dch_reg[i], dcl_reg[i]};
            end
            // Pin takes the PWM level only while on and driving.
            pin_out[i] <= (ctl_reg[i].on & ctl_reg[i].drive) ? lvl[i] : latch_reg[i];
            pin_oe[i]  <= ~dir_reg[i];
         end
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite write channel.
   // ----------------------------------------------------------------------
   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   wire wr_ok    = do_write & wstb_reg;
   wire [7:0] wa = wa_reg & 8'hFC;
   wire wr_hit_sh = (wa >= spwm_pkg::OFF_PERIOD) & (wa <= spwm_pkg::OFF_DIR);
   wire wr_hit_ch = (wa < ch_addr(NCH, 8'h00)) & (wa[3:2] != 2'h3);
   wire aw_have_next = (aw_have_reg | aw_take) & ~do_write;
   wire w_have_next  = (w_have_reg | w_take) & ~do_write;

   // Address and data are held separately and may arrive in either order.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         wa_reg        <= 8'h00;
         wd_reg        <= 8'h00;
         wstb_reg      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= spwm_pkg::RESP_OKAY;
      end else begin
         aw_have_reg   <= aw_have_next;
         w_have_reg    <= w_have_next;
         s_axi_awready <= ~aw_have_next;
         s_axi_wready  <= ~w_have_next;
         if (aw_take) begin
            wa_reg <= s_axi_awaddr[7:0];
         end
         if (w_take) begin
            wd_reg   <= s_axi_wdata[7:0];
            wstb_reg <= s_axi_wstrb[0];
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit_sh | wr_hit_ch) ? spwm_pkg::RESP_OKAY : spwm_pkg::RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes; the period flag set by hardware wins over a clear.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         period_reg <= spwm_pkg::PERIOD_RST;
         tbctl_reg  <= spwm_pkg::TBCTL_RST;
         flag_reg   <= 1'b0;
         latch_reg  <= '0;
         dir_reg    <= '1;
         for (int i = 0; i < NCH; i++) begin
            ctl_reg[i] <= '0;
            dch_reg[i] <= 8'h00;
            dcl_reg[i] <= 2'h0;
         end
      end else begin
         if (wr_ok && wa == spwm_pkg::OFF_PERIOD) period_reg <= wd_reg;
         if (wr_ok && wa == spwm_pkg::OFF_TBCTL)  tbctl_reg  <= wd_reg[6:0];
         if (wr_ok && wa == spwm_pkg::OFF_LATCH)  latch_reg  <= wd_reg[NCH-1:0];
         if (wr_ok && wa == spwm_pkg::OFF_DIR)    dir_reg    <= wd_reg[NCH-1:0];
         if (period_hit) begin
            flag_reg <= 1'b1;
         end else if (wr_ok && wa == spwm_pkg::OFF_STAT && wd_reg[spwm_pkg::STAT_FLG]) begin
            flag_reg <= 1'b0;
         end
         for (int i = 0; i < NCH; i++) begin
            if (wr_ok && wa == ch_addr(i, spwm_pkg::OFF_CON)) begin
               ctl_reg[i] <= {wd_reg[spwm_pkg::CON_ON], wd_reg[spwm_pkg::CON_DRV],
                              wd_reg[spwm_pkg::CON_INV]};
            end
            if (wr_ok && wa == ch_addr(i, spwm_pkg::OFF_DCH)) begin
               dch_reg[i] <= wd_reg;
            end
            if (wr_ok && wa == ch_addr(i, spwm_pkg::OFF_DCL)) begin
               dcl_reg[i] <= wd_reg[spwm_pkg::DCL_LSB +: 2];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read channel.
   // ----------------------------------------------------------------------
   logic [7:0] rd_byte;
   logic       rd_ok;
   wire  [7:0] ra = s_axi_araddr[7:0] & 8'hFC;
   wire  ar_take  = s_axi_arvalid & s_axi_arready;
   wire  rv_next  = ar_take | (s_axi_rvalid & ~s_axi_rready);

   // Read mux; unused bits read zero, unmapped addresses answer with an error.
   always_comb begin
      rd_byte = 8'h00;
      rd_ok   = 1'b1;
      case (ra)
         spwm_pkg::OFF_PERIOD: rd_byte = period_reg;
         spwm_pkg::OFF_TBCTL:  rd_byte = {1'b0, tbctl_reg};
         spwm_pkg::OFF_COUNT:  rd_byte = count_reg;
         spwm_pkg::OFF_STAT:   rd_byte = {7'h00, flag_reg};
         spwm_pkg::OFF_LATCH:  rd_byte = 8'(latch_reg);
         spwm_pkg::OFF_DIR:    rd_byte = 8'(dir_reg);
         default:              rd_ok   = 1'b0;
      endcase
      for (int i = 0; i < NCH; i++) begin
         if (ra == ch_addr(i, spwm_pkg::OFF_CON)) begin
            rd_ok   = 1'b1;
            rd_byte = {ctl_reg[i].on, ctl_reg[i].drive, lvl[i], ctl_reg[i].inv, 4'h0};
         end
         if (ra == ch_addr(i, spwm_pkg::OFF_DCH)) begin
            rd_ok   = 1'b1;
            rd_byte = dch_reg[i];
         end
         if (ra == ch_addr(i, spwm_pkg::OFF_DCL)) begin
            rd_ok   = 1'b1;
            rd_byte = {dcl_reg[i], 6'h00};
         end
      end
   end

   // One read in flight; arready drops until the data is taken.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= spwm_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~rv_next;
         s_axi_rvalid  <= rv_next;
         if (ar_take) begin
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_ok ? spwm_pkg::RESP_OKAY : spwm_pkg::RESP_ERR;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Assertions and cover points.
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   AST_CLEAR: assert property (period_hit |=> count_reg == 8'h00)
      else $error("timer not cleared after period match");
   AST_STEP: assert property (tick && !period_hit |=> count_reg == $past(count_reg) + 8'h01)
      else $error("timer step wrong");
   // A step at 1:1 is followed by exactly three quiet clocks, unless the
   // prescale is changed or the timer stops inside that window.
   AST_QUARTER: assert property (run && ps == 2'h0 && tick |=>
      !tick [*3] ##1 (tick || !run || ps != 2'h0))
      else $error("timer step not every four clocks at 1:1");
   AST_SUB: assert property (run && ps == 2'h0 |=>
      ps != 2'h0 || tb_now[1:0] == $past(tb_now[1:0]) + 2'h1)
      else $error("low time-base bits do not follow the clock");
   AST_BUF: assert property (period_hit |=>
      duty_buf_reg[0] == {$past(dch_reg[0]), $past(dcl_reg[0])})
      else $error("duty buffer not loaded at match");
   AST_HOLD: assert property (!period_hit |=> $stable(duty_buf_reg[0]))
      else $error("duty buffer changed outside match");
   AST_ZERO: assert property (run && duty_buf_reg[0] == 10'h000 |=> !raw_reg[0])
      else $error("zero duty produced an active output");
   AST_FULL: assert property (ctl_reg[0].on && full[0] && raw_reg[0] |=> raw_reg[0])
      else $error("full duty output was cleared");
   AST_OFF: assert property (!ctl_reg[0].on |=> !raw_reg[0])
      else $error("disabled channel active");
   AST_SLEEP: assert property (asleep_reg |=> $stable(count_reg) && $stable(raw_reg))
      else $error("state changed in sleep");
   AST_PIN: assert property (ctl_reg[0].on && ctl_reg[0].drive |=>
      pin_out[0] == $past(lvl[0]))
      else $error("pin does not follow channel level");
   AST_DIR: assert property (##1 pin_oe[0] == !$past(dir_reg[0]))
      else $error("pin enable does not follow direction");

   COV_MATCH: cover property (period_hit ##1 raw_reg[0]);
   COV_HIT:   cover property (hit[0] ##1 !raw_reg[0]);
   COV_FULL:  cover property (full[0] && raw_reg[0]);
   COV_SLEEP: cover property (asleep_reg ##1 !asleep_reg);
endmodule // spwm_top

// File: tb/spwm_tb.sv
// Self-checking bench for the shared time-base PWM block.
// Assumes spwm_pkg and spwm_top are compiled first; the bench is the only bus master.
`timescale 1ns/1ps
module tb;
   // ----------------------------------------------------------------------
   // Stimulus and observation signals.
   // ----------------------------------------------------------------------
   logic        core_clk  = 1'b0;
   logic        resetn    = 1'b0;
   logic [7:0]  awaddr    = 8'h00;
   logic        awvalid   = 1'b0;
   logic [31:0] wdata     = 32'h0000_0000;
   logic        wvalid    = 1'b0;
   logic        bready    = 1'b0;
   logic [7:0]  araddr    = 8'h00;
   logic        arvalid   = 1'b0;
   logic        rready    = 1'b0;
   logic        sleep_req = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [3:0]  pin_out, pin_oe;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          hcnt[4];

   // Free-running 50 MHz clock.
   always #10 core_clk = ~core_clk;

   spwm_top spwm_top_inst (
      .core_clk(core_clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sleep_req(sleep_req), .pin_out(pin_out), .pin_oe(pin_oe)
   );

   // ----------------------------------------------------------------------
   // Checking, verdict and bus tasks.
   // ----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Every wait is bounded; a hung handshake counts as a failure and ends the run.
   task automatic hang();
      check(32'h0, 32'h1);
      print_verdict();
   endtask

   // The first edge is waited for so that back-to-back calls never drive one signal twice.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      awaddr  <= a;
      wdata   <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            return;
         end
      end
      hang();
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            return;
         end
      end
      hang();
   endtask

   function automatic logic [7:0] ca(input int i, input logic [7:0] off);
      return off + spwm_pkg::CH_STRIDE * 8'(i);
   endfunction

   // High clocks in one period: duty times prescale, full period once duty passes the top.
   function automatic int exp_hi(input int d, input int p, input int ps);
      return (d > 4 * p + 3) ? 4 * (p + 1) * ps : d * ps;
   endfunction

   task automatic count_high(input int cyc);
      hcnt = '{0, 0, 0, 0};
      repeat (cyc) begin
         @(posedge core_clk);
         for (int i = 0; i < 4; i++) hcnt[i] += (pin_out[i] === 1'b1) ? 1 : 0;
      end
   endtask

   task automatic reset_checks();
      logic [31:0] v;
      logic [1:0]  r;
      check({28'h0, pin_oe}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rd(ca(i, spwm_pkg::OFF_CON), v, r);
         check(v, 32'h0);
      end
      rd(spwm_pkg::OFF_PERIOD, v, r);
      check(v, {24'h0, spwm_pkg::PERIOD_RST});
      rd(8'hF0, v, r);
      check({v[29:0], r}, {30'h0, spwm_pkg::RESP_ERR});
   endtask

   // ----------------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------------
   initial begin
      logic [31:0] v, c1;
      logic [1:0]  r;
      logic [7:0]  ctl;
      logic [3:0]  lv, inv, pv;
      int          p, psel, psv, per, rot, d[4];
      void'($urandom(32'hAD7A));
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      reset_checks();
      // Register access: control low nibble reads zero, output level bit written but masked from the compare, duty fields.
      for (int i = 0; i < 4; i++) begin
         ctl = 8'($urandom()) & 8'hDF;
         wr(ca(i, spwm_pkg::OFF_CON), ctl | 8'h2F);
         rd(ca(i, spwm_pkg::OFF_CON), v, r);
         check(v & 32'hDF, {24'h0, ctl & 8'hD0});
         wr(ca(i, spwm_pkg::OFF_DCL), 8'hFF);
         rd(ca(i, spwm_pkg::OFF_DCL), v, r);
         check(v, 32'hC0);
         wr(ca(i, spwm_pkg::OFF_DCH), ctl);
         rd(ca(i, spwm_pkg::OFF_DCH), v, r);
         check(v, {24'h0, ctl});
      end
      $display("test registers done");
      // Waveforms: random period, polarity, postscale and duty per channel; the
      // four prescales are all visited, and the period never shrinks, so the
      // running timer never has to wrap past a smaller limit.
      rot = $urandom_range(0, 3);
      for (int k = 0; k < 4; k++) begin
         p    = k + 2 + $urandom_range(0, 1);
         psel = (k + rot) % 4;
         psv  = 1 << (2 * psel);
         per  = 4 * (p + 1) * psv;
         inv  = 4'($urandom());
         for (int i = 0; i < 4; i++) d[i] = $urandom_range(0, 4 * p + 6);
         if (k == 0) d = '{4 * p + 4, 0, 4 * p + 3, 1};
         wr(spwm_pkg::OFF_DIR, 8'h00);
         wr(spwm_pkg::OFF_PERIOD, 8'(p));
         for (int i = 0; i < 4; i++) begin
            wr(ca(i, spwm_pkg::OFF_DCH), 8'(d[i] >> 2));
            wr(ca(i, spwm_pkg::OFF_DCL), 8'((d[i] & 3) << 6));
            wr(ca(i, spwm_pkg::OFF_CON), {3'h6, inv[i], 4'h0});
         end
         wr(spwm_pkg::OFF_STAT, 8'h01);
         wr(spwm_pkg::OFF_TBCTL, {1'b0, 3'($urandom()), 1'b1, 1'b1, 2'(psel)});
         repeat (4200) @(posedge core_clk);
         rd(spwm_pkg::OFF_STAT, v, r);
         check(v, 32'h1);
         count_high(2 * per);
         for (int i = 0; i < 4; i++)
            check(hcnt[i], inv[i] ? 2 * per - 2 * exp_hi(d[i], p, psv)
                                  : 2 * exp_hi(d[i], p, psv));
         check({28'h0, pin_oe}, 32'hF);
         // Channel 0 sits at full duty and channel 1 at zero in the first pass.
         if (k == 0) begin
            rd(ca(0, spwm_pkg::OFF_CON), v, r);
            check({31'h0, v[5]}, {31'h0, ~inv[0]});
            rd(ca(1, spwm_pkg::OFF_CON), v, r);
            check({31'h0, v[5]}, {31'h0, inv[1]});
         end
      end
      $display("test waveforms done");
      // Sleep freezes the count and the pins; wake resumes from the held count.
      // A long period at 1:1 keeps the count from wrapping inside the test.
      wr(spwm_pkg::OFF_PERIOD, 8'hFF);
      wr(spwm_pkg::OFF_TBCTL, 8'h04);
      repeat (300) @(posedge core_clk);
      sleep_req <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd(spwm_pkg::OFF_COUNT, c1, r);
      pv = pin_out;
      repeat (40) @(posedge core_clk);
      check({28'h0, pin_out}, {28'h0, pv});
      rd(spwm_pkg::OFF_COUNT, v, r);
      check(v, c1);
      sleep_req <= 1'b0;
      repeat (24) @(posedge core_clk);
      rd(spwm_pkg::OFF_COUNT, v, r);
      check(32'(v > c1 && v < c1 + 8), 32'h1);
      $display("test sleep done");
      // Pin drive off hands the pins to the port latch; enables follow direction.
      lv = 4'($urandom());
      wr(spwm_pkg::OFF_LATCH, {4'h0, lv});
      for (int i = 0; i < 4; i++) wr(ca(i, spwm_pkg::OFF_CON), 8'h80);
      wr(spwm_pkg::OFF_DIR, {4'h0, ~lv});
      repeat (4) @(posedge core_clk);
      check({28'h0, pin_out}, {28'h0, lv});
      check({28'h0, pin_oe}, {28'h0, lv});
      $display("test pin routing done");
      // Reset in mid-run returns registers and pins to their reset state.
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({28'h0, pin_out}, 32'h0);
      resetn <= 1'b1;
      reset_checks();
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule // tb
